// ### scs_regs.svh
`ifndef SCS_REGS_SVH
`define SCS_REGS_SVH

// Register byte offsets
`define SCS_CTRL_OFS        8'h00
`define SCS_FREQ_OFS        8'h04
`define SCS_STAT_OFS        8'h08
`define SCS_FRD_OFS         8'h0c

// Control fields and reset values
`define SCS_CTRL_PRECISE    0
`define SCS_CTRL_BUSF       1
`define SCS_CTRL_RST        2'h0
`define SCS_FREQ_RST        16'h0190

// Frequencies in kHz and divisor limits
`define SCS_CORE_KHZ        200000
`define SCS_REF_KHZ         8000
`define SCS_OUT_KHZ         400
`define SCS_LOW_KHZ         200
`define SCS_OPEN_KHZ        400
`define SCS_HIGH_KHZ        1000
`define SCS_FMIN_KHZ        200
`define SCS_FMAX_KHZ        1000
`define SCS_N_MIN           8
`define SCS_N_MAX           40

// Timing, in microseconds and derived core cycles, and the lock edge count
`define SCS_TIMEOUT_US      20
`define SCS_CYC_PER_N       (`SCS_CORE_KHZ / `SCS_REF_KHZ)
`define SCS_PMIN_CYC        (`SCS_CORE_KHZ / `SCS_FMAX_KHZ)
`define SCS_PMAX_CYC        (`SCS_CORE_KHZ / `SCS_FMIN_KHZ)
`define SCS_TIMEOUT_CYC     (`SCS_TIMEOUT_US * `SCS_CORE_KHZ / 1000)
`define SCS_LOCK_EDGES      3

`endif

// ### scs_pkg.sv
package scs_pkg;

  typedef enum logic [1:0] {
    SCS_LVL_LOW  = 2'h0,
    SCS_LVL_OPEN = 2'h1,
    SCS_LVL_HIGH = 2'h2,
    SCS_LVL_RES  = 2'h3
  } scs_lvl_t;

  typedef enum logic [3:0] {
    SCS_ST_IDLE   = 4'h1,
    SCS_ST_DETECT = 4'h2,
    SCS_ST_EXT    = 4'h4,
    SCS_ST_INT    = 4'h8
  } scs_state_t;

  typedef struct packed {
    logic [9:0] period;
    logic [5:0] div_n;
    logic [6:0] rsvd;
    logic       strap_taken;
    logic       fallback;
    logic       ext_lock;
    scs_lvl_t   cfg;
    scs_state_t state;
  } scs_status_t;

  typedef struct packed {
    logic     sync_pin;
    logic     enable;
    scs_lvl_t cfg_strap;
    scs_lvl_t sync_strap;
    logic [4:0] res_idx;
  } scs_pins_t;

endpackage

// ### scs_clock_select.sv
// The AXI4-Lite interface to the registers and the register offsets were chosen for this implementation.
`timescale 1ns/1ps
`include "scs_regs.svh"

module scs_clock_select
  import scs_pkg::*;
(
  input  wire logic        core_clk,
  input  wire logic        rst_n,
  input  wire logic        sync_in,
  output logic             sync_out,
  output logic             sync_oe,
  input  wire logic        enable_in,
  input  wire logic [1:0]  cfg_strap,
  input  wire logic [1:0]  sync_strap,
  input  wire logic [4:0]  frequency_set_resistor,
  output logic             sw_clk,
  output logic             pll_ref_ext,
  output logic             precise_ramp,
  input  wire logic [7:0]  s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  output logic [1:0]       s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  input  wire logic [7:0]  s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready
);

  localparam logic [11:0] TIMEOUT_CYC = 12'(`SCS_TIMEOUT_CYC);
  localparam logic [11:0] PMIN_CYC    = 12'(`SCS_PMIN_CYC);
  localparam logic [11:0] PMAX_CYC    = 12'(`SCS_PMAX_CYC);
  localparam logic [5:0]  N_MIN       = 6'(`SCS_N_MIN);
  localparam logic [5:0]  N_OUT       = 6'(`SCS_REF_KHZ / `SCS_OUT_KHZ);
  localparam logic [5:0]  N_LOW       = 6'(`SCS_REF_KHZ / `SCS_LOW_KHZ);
  localparam logic [5:0]  N_OPEN      = 6'(`SCS_REF_KHZ / `SCS_OPEN_KHZ);
  localparam logic [5:0]  N_HIGH      = 6'(`SCS_REF_KHZ / `SCS_HIGH_KHZ);
  localparam logic [1:0]  LOCK_EDGES  = 2'(`SCS_LOCK_EDGES);
  localparam int          NTHR        = `SCS_N_MAX - `SCS_N_MIN;

  // Resistor code to divisor; every tabulated frequency is an exact 8MHz/N
  localparam logic [5:0] RES_N [17] = '{6'h28, 6'h24, 6'h21, 6'h1e, 6'h1b, 6'h19,
                                         6'h16, 6'h14, 6'h13, 6'h11, 6'h0f, 6'h0e,
                                         6'h0d, 6'h0c, 6'h0b, 6'h09, 6'h08};

  // Quantised frequency in kHz for a divisor
  function automatic logic [15:0] n_to_khz(input logic [5:0] n);
    logic [15:0] f;
    f = 16'h0;
    for (int k = `SCS_N_MIN; k <= `SCS_N_MAX; k++) begin
      if (n == 6'(k)) begin
        f = 16'(`SCS_REF_KHZ / k);
      end
    end
    return f;
  endfunction

  // Pin synchronisers
  scs_pins_t   pins_in;
  scs_pins_t   meta_r;
  scs_pins_t   pins_r;
  logic        sync_d_r;
  logic        en_d_r;

  assign pins_in = '{sync_pin: sync_in, enable: enable_in, cfg_strap: scs_lvl_t'(cfg_strap),
                     sync_strap: scs_lvl_t'(sync_strap), res_idx: frequency_set_resistor};

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      meta_r   <= '0;
      pins_r   <= '0;
      sync_d_r <= 1'b0;
      en_d_r   <= 1'b0;
    end else begin
      meta_r   <= pins_in;
      pins_r   <= meta_r;
      sync_d_r <= pins_r.sync_pin;
      en_d_r   <= pins_r.enable;
    end
  end

  // Registers and state
  logic [1:0]  ctrl_r;
  logic [15:0] freq_req_r;
  scs_state_t  state_r;
  scs_state_t  state_nxt;
  scs_lvl_t    cfg_r;
  logic [5:0]  strap_n_r;
  logic        strap_taken_r;
  logic        fallback_r;
  logic [11:0] edge_cnt_r;
  logic [9:0]  meas_r;
  logic [1:0]  good_r;
  logic [9:0]  osc_cnt_r;

  wire en_rise  = pins_r.enable & ~en_d_r;
  wire en_fall  = ~pins_r.enable & en_d_r;
  wire precise  = ctrl_r[`SCS_CTRL_PRECISE];
  wire bus_freq = ctrl_r[`SCS_CTRL_BUSF];

  // Strap seen at the first start only, later ones reuse the stored value
  wire scs_lvl_t cfg_now = strap_taken_r ? cfg_r : pins_r.cfg_strap;
  wire is_out  = (cfg_now == SCS_LVL_HIGH);
  wire is_auto = (cfg_now == SCS_LVL_OPEN) || (cfg_now == SCS_LVL_RES);
  wire [5:0] res_n = (pins_r.res_idx <= 5'h10) ? RES_N[pins_r.res_idx] : N_OPEN;

  // Edge search only in DETECT and EXT; output mode never looks
  wire watching = (state_r == SCS_ST_DETECT) || (state_r == SCS_ST_EXT);
  wire ext_edge = watching && !is_out && pins_r.sync_pin && !sync_d_r;
  wire [11:0] gap = edge_cnt_r + 12'h1;
  wire gap_ok   = (gap >= PMIN_CYC) && (gap <= PMAX_CYC);
  wire timed_out = watching && (edge_cnt_r >= TIMEOUT_CYC);

  // Nearest 8MHz/N: count how many N-to-N+1 midpoints lie above the request
  logic [NTHR-1:0] below;
  genvar gi;
  generate
    for (gi = 0; gi < NTHR; gi++) begin : g_thr
      localparam int NN  = `SCS_N_MIN + gi;
      localparam int THR = (`SCS_REF_KHZ / 2) * (2 * NN + 1) / (NN * (NN + 1));
      assign below[gi] = (freq_req_r < 16'(THR));
    end
  endgenerate

  logic [5:0] n_bus;
  always_comb begin
    n_bus = N_MIN;
    for (int i = 0; i < NTHR; i++) begin
      n_bus = n_bus + 6'(below[i]);
    end
  end

  wire [5:0] n_int = is_out                     ? N_OUT :
                     bus_freq                   ? n_bus :
                     (is_auto && strap_taken_r) ? strap_n_r :
                     N_OPEN;
  wire [9:0] period_int = 10'(n_int) * 10'(`SCS_CYC_PER_N);
  wire use_meas = (state_r == SCS_ST_EXT) || fallback_r;
  wire [9:0] period_act = use_meas ? meas_r : period_int;

  // Start-up detection sequencer
  always_comb begin
    state_nxt = state_r;
    unique case (state_r)
      SCS_ST_IDLE: begin
        if (en_rise) begin
          if (is_out || (is_auto && precise)) begin
            state_nxt = SCS_ST_INT;
          end else begin
            state_nxt = SCS_ST_DETECT;
          end
        end
      end
      SCS_ST_DETECT: begin
        if (ext_edge && gap_ok && good_r == LOCK_EDGES - 2'h1) begin
          state_nxt = SCS_ST_EXT;
        end else if (timed_out) begin
          state_nxt = SCS_ST_INT;
        end
      end
      SCS_ST_EXT: begin
        if (timed_out || (ext_edge && !gap_ok)) begin
          state_nxt = SCS_ST_INT;
        end
      end
      SCS_ST_INT: state_nxt = SCS_ST_INT;
      default: state_nxt = SCS_ST_IDLE;
    endcase
    if (en_fall) begin
      state_nxt = SCS_ST_IDLE;
    end
  end

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      state_r       <= SCS_ST_IDLE;
      cfg_r         <= SCS_LVL_LOW;
      strap_n_r     <= N_OPEN;
      strap_taken_r <= 1'b0;
    end else begin
      state_r <= state_nxt;
      if (en_rise && !strap_taken_r) begin
        strap_taken_r <= 1'b1;
        cfg_r         <= pins_r.cfg_strap;
        unique case (pins_r.sync_strap)
          SCS_LVL_LOW:  strap_n_r <= N_LOW;
          SCS_LVL_OPEN: strap_n_r <= N_OPEN;
          SCS_LVL_HIGH: strap_n_r <= N_HIGH;
          SCS_LVL_RES:  strap_n_r <= res_n;
        endcase
      end
    end
  end

  // Edge timing: gap counter, last good period, lock qualification
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      edge_cnt_r <= 12'h0;
      meas_r     <= 10'h0;
      good_r     <= 2'h0;
      fallback_r <= 1'b0;
    end else begin
      if (en_rise || ext_edge) begin
        edge_cnt_r <= 12'h0;
      end else if (edge_cnt_r < TIMEOUT_CYC) begin
        edge_cnt_r <= edge_cnt_r + 12'h1;
      end
      if (en_rise) begin
        good_r     <= 2'h0;
        fallback_r <= 1'b0;
      end else if (ext_edge) begin
        // First edge only opens the gap; no period can be trusted before it
        if (good_r == 2'h0) begin
          good_r <= 2'h1;
        end else if (gap_ok) begin
          meas_r <= gap[9:0];
          if (good_r != LOCK_EDGES) begin
            good_r <= good_r + 2'h1;
          end
        end else begin
          good_r <= 2'h1;
        end
      end
      if (state_r == SCS_ST_EXT && state_nxt == SCS_ST_INT) begin
        fallback_r <= 1'b1;
      end
    end
  end

  // Internal oscillator, restarted on each external rising edge when locked
  wire [9:0] osc_nxt = (ext_edge && state_r == SCS_ST_EXT) ? 10'h0 :
                       (osc_cnt_r >= period_act - 10'h1)   ? 10'h0 :
                       osc_cnt_r + 10'h1;
  wire osc_hi = (osc_nxt < (period_act >> 1));

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      osc_cnt_r   <= 10'h0;
      sw_clk      <= 1'b0;
      sync_out    <= 1'b0;
      sync_oe     <= 1'b0;
      pll_ref_ext <= 1'b0;
    end else begin
      osc_cnt_r   <= osc_nxt;
      sw_clk      <= osc_hi;
      sync_out    <= osc_hi && strap_taken_r && cfg_r == SCS_LVL_HIGH;
      sync_oe     <= strap_taken_r && cfg_r == SCS_LVL_HIGH;
      pll_ref_ext <= (state_nxt == SCS_ST_EXT);
    end
  end

  // AXI4-Lite slave
  logic [7:0]  aw_addr_r;
  logic [31:0] w_data_r;
  logic [3:0]  w_strb_r;
  scs_status_t status;

  wire do_write = !s_axi_awready && !s_axi_wready && !s_axi_bvalid;
  wire [7:0] wa = aw_addr_r;
  wire wr_ctrl  = (wa == `SCS_CTRL_OFS);
  wire wr_freq  = (wa == `SCS_FREQ_OFS);
  wire wr_hit   = wr_ctrl || wr_freq || (wa == `SCS_STAT_OFS) || (wa == `SCS_FRD_OFS);
  wire rd_hit   = (s_axi_araddr == `SCS_CTRL_OFS) || (s_axi_araddr == `SCS_FREQ_OFS) ||
                  (s_axi_araddr == `SCS_STAT_OFS) || (s_axi_araddr == `SCS_FRD_OFS);

  assign status = '{period: period_act, div_n: n_int, rsvd: '0, strap_taken: strap_taken_r,
                    fallback: fallback_r, ext_lock: (state_r == SCS_ST_EXT),
                    cfg: cfg_r, state: state_r};

  wire [31:0] rd_mux =
    (s_axi_araddr == `SCS_CTRL_OFS) ? {30'h0, ctrl_r} :
    (s_axi_araddr == `SCS_FREQ_OFS) ? {16'h0, freq_req_r} :
    (s_axi_araddr == `SCS_STAT_OFS) ? status :
    (s_axi_araddr == `SCS_FRD_OFS)  ? {16'h0, n_to_khz(n_int)} :
    32'h0;

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      s_axi_awready <= 1'b1;
      s_axi_wready  <= 1'b1;
      s_axi_bvalid  <= 1'b0;
      s_axi_bresp   <= 2'h0;
      aw_addr_r     <= 8'h0;
      w_data_r      <= 32'h0;
      w_strb_r      <= 4'h0;
      ctrl_r        <= `SCS_CTRL_RST;
      freq_req_r    <= `SCS_FREQ_RST;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_addr_r     <= {s_axi_awaddr[7:2], 2'h0};
        s_axi_awready <= 1'b0;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_data_r     <= s_axi_wdata;
        w_strb_r     <= s_axi_wstrb;
        s_axi_wready <= 1'b0;
      end
      if (do_write) begin
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= wr_hit ? 2'h0 : 2'h3;
        if (wr_ctrl && w_strb_r[0]) begin
          ctrl_r <= w_data_r[1:0];
        end
        if (wr_freq && w_strb_r[0]) begin
          freq_req_r[7:0] <= w_data_r[7:0];
        end
        if (wr_freq && w_strb_r[1]) begin
          freq_req_r[15:8] <= w_data_r[15:8];
        end
      end
      if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid  <= 1'b0;
        s_axi_awready <= 1'b1;
        s_axi_wready  <= 1'b1;
      end
    end
  end

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      s_axi_arready <= 1'b1;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= 32'h0;
      s_axi_rresp   <= 2'h0;
      precise_ramp  <= 1'b0;
    end else begin
      precise_ramp <= precise;
      if (s_axi_arvalid && s_axi_arready) begin
        s_axi_arready <= 1'b0;
        s_axi_rvalid  <= 1'b1;
        s_axi_rdata   <= rd_mux;
        s_axi_rresp   <= rd_hit ? 2'h0 : 2'h3;
      end else if (s_axi_rvalid && s_axi_rready) begin
        s_axi_rvalid  <= 1'b0;
        s_axi_arready <= 1'b1;
      end
    end
  end

endmodule

// ### scs_clock_select_props.sv
`timescale 1ns/1ps
module scs_clock_select_props (
  input wire logic        core_clk,
  input wire logic        rst_n,
  input wire logic        sync_in,
  input wire logic        sync_out,
  input wire logic        sync_oe,
  input wire logic        enable_in,
  input wire logic        sw_clk,
  input wire logic        pll_ref_ext,
  input wire logic        s_axi_awvalid,
  input wire logic        s_axi_awready,
  input wire logic        s_axi_wvalid,
  input wire logic        s_axi_wready,
  input wire logic [1:0]  s_axi_bresp,
  input wire logic        s_axi_bvalid,
  input wire logic        s_axi_bready,
  input wire logic        s_axi_arvalid,
  input wire logic        s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic        s_axi_rvalid,
  input wire logic        s_axi_rready
);
  logic [12:0] age_r;
  logic [9:0]  run_r;

  // Cycles since the last rising pin edge and since the last output change
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      age_r <= '0;
      run_r <= '0;
    end else begin
      if ($rose(sync_in)) age_r <= '0;
      else if (age_r != 13'h1fff) age_r <= age_r + 13'd1;
      if ($changed(sync_out)) run_r <= 10'd1;
      else if (run_r != 10'h3ff) run_r <= run_r + 10'd1;
    end
  end

  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rst_n);

  sequence both_taken;
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
  endsequence
  sequence en_gone;
    !enable_in [*8];
  endsequence

  bresp_time_a: assert property (both_taken |=> !s_axi_awready ##[0:1] s_axi_bvalid)
    else $error("write response missing");
  bresp_hold_a: assert property (s_axi_bvalid && !s_axi_bready |=>
    s_axi_bvalid && $stable(s_axi_bresp))
    else $error("write response dropped");
  rdata_hold_a: assert property (s_axi_rvalid && !s_axi_rready |=>
    s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read data dropped");
  read_time_a: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("read answer late");
  out_nolock_a: assert property (sync_oe |-> !pll_ref_ext)
    else $error("output mode locked to pin");
  out_half_a: assert property (sync_oe && $past(sync_oe, 300) |-> run_r <= 10'd250)
    else $error("sync output half period too long");
  lock_edge_a: assert property ($rose(pll_ref_ext) |-> age_r <= 13'd8)
    else $error("lock without recent pin edge");
  lock_quiet_a: assert property (pll_ref_ext |-> age_r <= 13'd4016)
    else $error("lock held through silence");
  en_drop_a: assert property (en_gone |-> !pll_ref_ext)
    else $error("lock held without enable");
  clk_align_a: assert property (pll_ref_ext && $rose(sync_in) |-> ##[2:8] sw_clk)
    else $error("switching clock not aligned");
endmodule

bind scs_clock_select scs_clock_select_props i_props (.*);

// ### scs_sync_peer.sv
`timescale 1ns/1ps
module scs_sync_peer (
  input  wire logic       core_clk,
  input  wire logic       run,
  input  wire logic [9:0] half,
  output logic            drv,
  output logic            oe
);
  logic [9:0] cnt_r;

  initial {cnt_r, drv, oe} = '0;

  // Falling edge keeps the peer out of phase with the device
  always @(negedge core_clk) begin
    oe <= run;
    if (!run) begin
      cnt_r <= '0;
      drv <= 1'b0;
    end else if (cnt_r >= half - 10'd1) begin
      cnt_r <= '0;
      drv <= !drv;
    end else begin
      cnt_r <= cnt_r + 10'd1;
    end
  end
endmodule

// ### tb_top.sv
`timescale 1ns/1ps
module tb_top
  import scs_pkg::*;
();
  logic        core_clk = 1'b0;
  logic        rst_n, enable_in, sync_in, sync_out, sync_oe, sw_clk;
  logic        pll_ref_ext, precise_ramp, float_r, p_run, p_drv, p_oe;
  logic [1:0]  cfg_strap, sync_strap, s_axi_bresp, s_axi_rresp, r;
  logic [4:0]  frequency_set_resistor;
  logic [9:0]  p_half;
  logic [7:0]  s_axi_awaddr, s_axi_araddr;
  logic [31:0] s_axi_wdata, s_axi_rdata, d;
  logic [3:0]  s_axi_wstrb;
  logic        s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
  logic        s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready;
  logic        s_axi_rvalid, s_axi_rready;
  int          error_cnt = 0;
  int          total_checks = 0;
  scs_status_t st;

  scs_clock_select i_dut (.*);
  scs_sync_peer i_peer (.core_clk, .run(p_run), .half(p_half), .drv(p_drv), .oe(p_oe));

  // Undriven line keeps the inverse of its last level, never a fake zero
  assign sync_in = sync_oe ? sync_out : (p_oe ? p_drv : float_r);
  always @(posedge core_clk) if (sync_oe || p_oe) float_r <= !sync_in;
  always #2.5 core_clk = !core_clk;

  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    total_checks++;
    if (g !== e) begin
      error_cnt++;
      $display("ERROR t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] v, output logic [1:0] rs);
    @(posedge core_clk);
    s_axi_awaddr <= a;
    s_axi_wdata <= v;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    // Only the watchdog ends a wait for the slave
    do begin
      @(posedge core_clk);
      if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'b0;
    end while (!s_axi_bvalid);
    rs = s_axi_bresp;
    s_axi_bready <= 1'b0;
  endtask

  task automatic rd(input logic [7:0] a, output logic [31:0] v, output logic [1:0] rs);
    @(posedge core_clk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do begin
      @(posedge core_clk);
      if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'b0;
    end while (!s_axi_rvalid);
    v = s_axi_rdata;
    rs = s_axi_rresp;
    s_axi_rready <= 1'b0;
  endtask

  task automatic rc(input logic [7:0] a, input logic [31:0] e);
    rd(a, d, r);
    chk(d, e);
  endtask

  task automatic rs_stat;
    rd(8'h08, d, r);
    st = d;
  endtask

  task automatic per(ref logic s, input int e);
    realtime t0;
    @(posedge s);
    t0 = $realtime;
    @(posedge s);
    chk(int'(($realtime - t0) / 5.0), e);
  endtask

  task automatic start(input logic [1:0] c, input logic [1:0] s, input logic [4:0] f);
    @(posedge core_clk);
    rst_n <= 1'b0;
    enable_in <= 1'b0;
    p_run <= 1'b0;
    cfg_strap <= c;
    sync_strap <= s;
    frequency_set_resistor <= f;
    repeat (10) @(posedge core_clk);
    rst_n <= 1'b1;
  endtask

  task automatic go(input int n);
    @(posedge core_clk);
    enable_in <= 1'b1;
    repeat (n) @(posedge core_clk);
  endtask

  task automatic t_regs;
    start(2'h0, 2'h1, 5'h0);
    rc(8'h00, 32'h0);
    rc(8'h04, 32'h190);
    wr(8'h08, 32'hffffffff, r);
    chk(r, 2'h0);
    rs_stat();
    chk(st.state, SCS_ST_IDLE);
    wr(8'h40, 32'h1, r);
    chk(r, 2'h3);
    rd(8'h40, d, r);
    chk(d, 32'h0);
    chk(r, 2'h3);
    wr(8'h00, 32'h1, r);
    repeat (2) @(posedge core_clk);
    chk(precise_ramp, 1'b1);
  endtask

  task automatic t_bus;
    logic [31:0] q[3] = '{810, 221, 2000};
    int f[3] = '{800, 222, 1000};
    int n[3] = '{10, 36, 8};
    for (int i = 0; i < 3; i++) begin
      start(2'h0, 2'h1, 5'h0);
      wr(8'h04, q[i], r);
      wr(8'h00, 32'h2, r);
      go(4300);
      rc(8'h0c, f[i]);
      rs_stat();
      chk(st.div_n, n[i]);
      per(sw_clk, 25 * n[i]);
    end
  endtask

  task automatic t_out;
    start(2'h2, 2'h1, 5'h0);
    go(20);
    chk(sync_oe, 1'b1);
    per(sync_out, 500);
    repeat (4300) @(posedge core_clk);
    chk(pll_ref_ext, 1'b0);
    rs_stat();
    chk(st.state, SCS_ST_INT);
  endtask

  task automatic t_ext;
    start(2'h0, 2'h1, 5'h0);
    // Off the 400kHz default, so a fallback to the default would show
    p_half <= 10'd200;
    p_run <= 1'b1;
    repeat (600) @(posedge core_clk);
    go(2500);
    chk(pll_ref_ext, 1'b1);
    per(sw_clk, 400);
    @(posedge p_drv);
    @(posedge core_clk);
    p_run <= 1'b0;
    repeat (4300) @(posedge core_clk);
    chk(pll_ref_ext, 1'b0);
    rs_stat();
    chk(st.fallback, 1'b1);
    chk(st.period, 10'd400);
    per(sw_clk, 400);
    enable_in <= 1'b0;
    p_half <= 10'd100;
    p_run <= 1'b1;
    repeat (600) @(posedge core_clk);
    go(1200);
    chk(pll_ref_ext, 1'b1);
    per(sw_clk, 200);
  endtask

  task automatic t_auto;
    logic [1:0] ss[5] = '{2'h0, 2'h1, 2'h2, 2'h3, 2'h3};
    logic [4:0] fr[5] = '{5'h0, 5'h0, 5'h0, 5'h1, 5'h10};
    int kh[5] = '{200, 400, 1000, 222, 1000};
    for (int i = 0; i < 5; i++) begin
      start(2'h1, ss[i], fr[i]);
      go(4300);
      rc(8'h0c, kh[i]);
      per(sw_clk, 200000 / kh[i]);
      sync_strap <= (ss[i] == 2'h0) ? 2'h2 : 2'h0;
      frequency_set_resistor <= 5'h8;
      enable_in <= 1'b0;
      repeat (20) @(posedge core_clk);
      go(4300);
      rc(8'h0c, kh[i]);
    end
  endtask

  task automatic t_prec;
    start(2'h1, 2'h1, 5'h0);
    wr(8'h00, 32'h1, r);
    p_half <= 10'd250;
    p_run <= 1'b1;
    repeat (600) @(posedge core_clk);
    go(2500);
    chk(pll_ref_ext, 1'b0);
    rs_stat();
    chk(st.state, SCS_ST_INT);
  endtask

  task automatic conclude;
    $display("checks=%0d errors=%0d", total_checks, error_cnt);
    if (error_cnt == 0 && total_checks > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask

  initial begin
    {rst_n, enable_in, p_run, float_r, s_axi_awvalid, s_axi_wvalid} = '0;
    {s_axi_bready, s_axi_arvalid, s_axi_rready, s_axi_awaddr, s_axi_araddr} = '0;
    {cfg_strap, sync_strap, frequency_set_resistor, s_axi_wdata} = '0;
    s_axi_wstrb = 4'hf;
    p_half = 10'd250;
    t_regs();
    t_bus();
    t_out();
    t_ext();
    t_auto();
    t_prec();
    conclude();
  end

  // Whole run needs roughly 80000 cycles
  initial begin
    repeat (100000) @(posedge core_clk);
    error_cnt++;
    conclude();
  end
endmodule
